//--- logic/dft_frame_timing.sv
// The Wishbone slave port was decided locally.
`timescale 1ns/100ps
module dft_frame_timing
   import dft_pkg::*;
(
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        reset,
   // Wishbone slave.
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [11:0] adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // Panel path.
   output logic             panelPixelStrobe,
   output logic             panelDisplayEnable,
   output logic             panelLineStart,
   output logic             panelFrameStart,
   // Monitor or television path.
   output logic             monitorPixelStrobe,
   output logic             monitorDisplayEnable,
   output logic             monitorLineStart,
   output logic             monitorFrameStart
);

   // ----------------------------------------------------------------
   // Field decoding.
   // ----------------------------------------------------------------
   function automatic logic [11:0] timesEight(input logic [6:0] field);
      logic [11:0] wide;
      wide = {5'h00, field};
      timesEight = (wide + 12'h001) * PIXELS_PER_COL;
   endfunction : timesEight

   function automatic logic [10:0] heightOf(input logic [7:0] high, input logic [7:0] low);
      heightOf = {1'b0, high[1:0], low} + ONE_LINE;
   endfunction : heightOf

   // ----------------------------------------------------------------
   // Registers.
   // ----------------------------------------------------------------
   logic [7:0] lcdHdispWidth;
   logic [7:0] lcdHnondispPeriod;
   logic [7:0] lcdVdispHeightLow;
   logic [7:0] lcdVdispHeightHigh;
   logic [7:0] lcdVnondispPeriod;
   logic [7:0] crtHdispWidth;
   logic [7:0] crtHnondispPeriod;
   logic [7:0] crtVdispHeightLow;
   logic [7:0] crtVdispHeightHigh;
   logic [7:0] crtVnondispPeriod;
   logic [7:0] pathControl;
   logic [7:0] pixelDivider;
   logic [9:0] index;
   logic       busWrite;

   assign index    = adr_i[11:2];
   assign busWrite = cyc_i && stb_i && we_i && ack_o && sel_i[0];

   // ----------------------------------------------------------------
   // Register writes.
   // ----------------------------------------------------------------
   // A write lands at the edge where the master sees ack high.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         lcdHdispWidth <= REG_RESET;
      end else if (busWrite && index == IDX_LCD_HDISP_WIDTH) begin
         lcdHdispWidth <= dat_i[7:0];
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         lcdHnondispPeriod <= REG_RESET;
      end else if (busWrite && index == IDX_LCD_HNONDISP_PERIOD) begin
         lcdHnondispPeriod <= dat_i[7:0];
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         lcdVdispHeightLow <= REG_RESET;
      end else if (busWrite && index == IDX_LCD_VDISP_HEIGHT_LOW) begin
         lcdVdispHeightLow <= dat_i[7:0];
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         lcdVdispHeightHigh <= REG_RESET;
      end else if (busWrite && index == IDX_LCD_VDISP_HEIGHT_HIGH) begin
         lcdVdispHeightHigh <= dat_i[7:0];
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         lcdVnondispPeriod <= REG_RESET;
      end else if (busWrite && index == IDX_LCD_VNONDISP_PERIOD) begin
         lcdVnondispPeriod <= dat_i[7:0];
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         crtHdispWidth <= REG_RESET;
      end else if (busWrite && index == IDX_CRT_HDISP_WIDTH) begin
         crtHdispWidth <= dat_i[7:0];
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         crtHnondispPeriod <= REG_RESET;
      end else if (busWrite && index == IDX_CRT_HNONDISP_PERIOD) begin
         crtHnondispPeriod <= dat_i[7:0];
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         crtVdispHeightLow <= REG_RESET;
      end else if (busWrite && index == IDX_CRT_VDISP_HEIGHT_LOW) begin
         crtVdispHeightLow <= dat_i[7:0];
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         crtVdispHeightHigh <= REG_RESET;
      end else if (busWrite && index == IDX_CRT_VDISP_HEIGHT_HIGH) begin
         crtVdispHeightHigh <= dat_i[7:0];
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         crtVnondispPeriod <= REG_RESET;
      end else if (busWrite && index == IDX_CRT_VNONDISP_PERIOD) begin
         crtVnondispPeriod <= dat_i[7:0];
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pathControl <= REG_RESET;
      end else if (busWrite && index == IDX_PATH_CONTROL) begin
         pathControl <= dat_i[7:0];
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pixelDivider <= REG_RESET;
      end else if (busWrite && index == IDX_PIXEL_DIVIDER) begin
         pixelDivider <= dat_i[7:0];
      end
   end

   // ----------------------------------------------------------------
   // Per-path limits in pixels and lines.
   // ----------------------------------------------------------------
   logic        pathOn    [2];
   logic [3:0]  divVal    [2];
   logic [11:0] hActLim   [2];
   logic [11:0] hTotLim   [2];
   logic [10:0] vActLim   [2];
   logic [10:0] vTotLim   [2];
   logic        halfLast  [2];
   logic [10:0] panelLines;
   logic [10:0] monLines;
   logic [10:0] monBlank;
   logic [11:0] monHBlank;
   logic        teleMode;

   assign teleMode   = pathControl[CTL_TELE_MODE];
   assign panelLines = heightOf(lcdVdispHeightHigh, lcdVdispHeightLow);
   assign monLines   = heightOf(crtVdispHeightHigh, crtVdispHeightLow);
   assign monBlank   = {4'h0, crtVnondispPeriod[6:0]} + ONE_LINE;

   always_comb begin
      if (teleMode) begin
         monHBlank = {3'h0, crtHnondispPeriod[5:0], 3'h0}
                   + (pathControl[CTL_PAL] ? PAL_EXTRA : NTSC_EXTRA);
      end else begin
         monHBlank = timesEight({1'b0, crtHnondispPeriod[5:0]});
      end
   end

   always_comb begin
      pathOn[0]   = pathControl[CTL_PANEL_ON];
      pathOn[1]   = pathControl[CTL_MON_ON];
      divVal[0]   = pixelDivider[3:0];
      divVal[1]   = pixelDivider[7:4];
      hActLim[0]  = timesEight(lcdHdispWidth[6:0]);
      hTotLim[0]  = hActLim[0] + timesEight({2'h0, lcdHnondispPeriod[4:0]});
      if (pathControl[CTL_PANEL_DUAL]) begin
         vActLim[0] = (panelLines + ONE_LINE) >> 1;
      end else begin
         vActLim[0] = panelLines;
      end
      vTotLim[0]  = vActLim[0] + {5'h00, lcdVnondispPeriod[5:0]} + ONE_LINE;
      halfLast[0] = 1'b0;
      hActLim[1]  = timesEight(crtHdispWidth[6:0]);
      hTotLim[1]  = hActLim[1] + monHBlank;
      vActLim[1]  = monLines;
      vTotLim[1]  = monLines + monBlank + (teleMode ? ONE_LINE : 11'h000);
      halfLast[1] = teleMode;
   end

   // ----------------------------------------------------------------
   // Per-path pixel strobe and raster counters.
   // ----------------------------------------------------------------
   logic [3:0]  divCnt   [2];
   logic        pxEn     [2];
   logic [11:0] hCount   [2];
   logic [10:0] vCount   [2];
   logic [1:0]  dispOut;
   logic [1:0]  lineOut;
   logic [1:0]  frameOut;
   logic [1:0]  strobeOut;

   for (genvar i = 0; i < 2; i++) begin : gPath
      logic        lastLine;
      logic [11:0] lineLen;
      logic        lineEnd;

      assign lastLine = vCount[i] >= (vTotLim[i] - ONE_LINE);
      assign lineLen  = (halfLast[i] && lastLine) ? (hTotLim[i] >> 1) : hTotLim[i];
      assign lineEnd  = hCount[i] >= (lineLen - 12'h001);
      assign pxEn[i]  = pathOn[i] && (divCnt[i] >= divVal[i]);

      always_ff @(posedge clk or posedge reset) begin
         if (reset) begin
            divCnt[i] <= 4'h0;
         end else if (!pathOn[i] || pxEn[i]) begin
            divCnt[i] <= 4'h0;
         end else begin
            divCnt[i] <= divCnt[i] + 4'h1;
         end
      end

      always_ff @(posedge clk or posedge reset) begin
         if (reset) begin
            hCount[i] <= 12'h000;
         end else if (!pathOn[i]) begin
            hCount[i] <= 12'h000;
         end else if (pxEn[i]) begin
            hCount[i] <= lineEnd ? 12'h000 : hCount[i] + 12'h001;
         end
      end

      always_ff @(posedge clk or posedge reset) begin
         if (reset) begin
            vCount[i] <= 11'h000;
         end else if (!pathOn[i]) begin
            vCount[i] <= 11'h000;
         end else if (pxEn[i] && lineEnd) begin
            vCount[i] <= lastLine ? 11'h000 : vCount[i] + ONE_LINE;
         end
      end

      always_ff @(posedge clk or posedge reset) begin
         if (reset) begin
            dispOut[i] <= 1'b0;
         end else begin
            dispOut[i] <= pathOn[i] && (hCount[i] < hActLim[i]) && (vCount[i] < vActLim[i]);
         end
      end

      always_ff @(posedge clk or posedge reset) begin
         if (reset) begin
            lineOut[i]   <= 1'b0;
            frameOut[i]  <= 1'b0;
            strobeOut[i] <= 1'b0;
         end else begin
            lineOut[i]   <= pxEn[i] && lineEnd;
            frameOut[i]  <= pxEn[i] && lineEnd && lastLine;
            strobeOut[i] <= pxEn[i];
         end
      end
   end

   assign panelPixelStrobe     = strobeOut[0];
   assign panelDisplayEnable   = dispOut[0];
   assign panelLineStart       = lineOut[0];
   assign panelFrameStart      = frameOut[0];
   assign monitorPixelStrobe   = strobeOut[1];
   assign monitorDisplayEnable = dispOut[1];
   assign monitorLineStart     = lineOut[1];
   assign monitorFrameStart    = frameOut[1];

   // ----------------------------------------------------------------
   // Status bits.
   // ----------------------------------------------------------------
   logic panelVBlank;
   logic monitorVBlank;

   assign panelVBlank   = vCount[0] >= vActLim[0];
   assign monitorVBlank = vCount[1] >= vActLim[1];

   // ----------------------------------------------------------------
   // Bus answer.
   // ----------------------------------------------------------------
   logic [31:0] next_dat;

   always_comb begin
      next_dat = 32'h0000_0000;
      case (index)
         IDX_LCD_HDISP_WIDTH:       next_dat[7:0]  = lcdHdispWidth;
         IDX_LCD_HNONDISP_PERIOD:   next_dat[7:0]  = lcdHnondispPeriod;
         IDX_LCD_VDISP_HEIGHT_LOW:  next_dat[7:0]  = lcdVdispHeightLow;
         IDX_LCD_VDISP_HEIGHT_HIGH: next_dat[7:0]  = lcdVdispHeightHigh;
         IDX_LCD_VNONDISP_PERIOD:   next_dat[7:0]  = lcdVnondispPeriod;
         IDX_CRT_HDISP_WIDTH:       next_dat[7:0]  = crtHdispWidth;
         IDX_CRT_HNONDISP_PERIOD:   next_dat[7:0]  = crtHnondispPeriod;
         IDX_CRT_VDISP_HEIGHT_LOW:  next_dat[7:0]  = crtVdispHeightLow;
         IDX_CRT_VDISP_HEIGHT_HIGH: next_dat[7:0]  = crtVdispHeightHigh;
         IDX_CRT_VNONDISP_PERIOD:   next_dat[7:0]  = crtVnondispPeriod;
         IDX_PATH_CONTROL:          next_dat[7:0]  = pathControl;
         IDX_PIXEL_DIVIDER:         next_dat[7:0]  = pixelDivider;
         IDX_PATH_STATUS:           next_dat[3:0]  = {monitorVBlank, dispOut[1],
                                                      panelVBlank, dispOut[0]};
         IDX_PANEL_LINE:            next_dat[10:0] = vCount[0];
         IDX_MONITOR_LINE:          next_dat[10:0] = vCount[1];
         default:                   next_dat       = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= cyc_i && stb_i && !ack_o;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         dat_o <= 32'h0000_0000;
      end else begin
         dat_o <= (cyc_i && stb_i && !we_i && !ack_o) ? next_dat : 32'h0000_0000;
      end
   end

endmodule : dft_frame_timing

//--- logic/dft_pkg.sv
package dft_pkg;

   // ----------------------------------------------------------------
   // Register indices; the byte address is four times the index.
   // ----------------------------------------------------------------
   localparam logic [9:0] IDX_LCD_HDISP_WIDTH       = 10'h032;
   localparam logic [9:0] IDX_LCD_HNONDISP_PERIOD   = 10'h034;
   localparam logic [9:0] IDX_LCD_VDISP_HEIGHT_LOW  = 10'h038;
   localparam logic [9:0] IDX_LCD_VDISP_HEIGHT_HIGH = 10'h039;
   localparam logic [9:0] IDX_LCD_VNONDISP_PERIOD   = 10'h03a;
   localparam logic [9:0] IDX_CRT_HDISP_WIDTH       = 10'h050;
   localparam logic [9:0] IDX_CRT_HNONDISP_PERIOD   = 10'h052;
   localparam logic [9:0] IDX_CRT_VDISP_HEIGHT_LOW  = 10'h056;
   localparam logic [9:0] IDX_CRT_VDISP_HEIGHT_HIGH = 10'h057;
   localparam logic [9:0] IDX_CRT_VNONDISP_PERIOD   = 10'h058;
   localparam logic [9:0] IDX_PATH_CONTROL          = 10'h0f0;
   localparam logic [9:0] IDX_PIXEL_DIVIDER         = 10'h0f1;
   localparam logic [9:0] IDX_PATH_STATUS           = 10'h0f2;
   localparam logic [9:0] IDX_PANEL_LINE            = 10'h0f3;
   localparam logic [9:0] IDX_MONITOR_LINE          = 10'h0f4;

   // ----------------------------------------------------------------
   // Control bit positions.
   // ----------------------------------------------------------------
   localparam int CTL_PANEL_ON   = 0;
   localparam int CTL_PANEL_DUAL = 1;
   localparam int CTL_MON_ON     = 2;
   localparam int CTL_TELE_MODE  = 3;
   localparam int CTL_PAL        = 4;

   // ----------------------------------------------------------------
   // Reset values and timing counts.
   // ----------------------------------------------------------------
   localparam logic [7:0]  REG_RESET      = 8'h00;
   localparam logic [11:0] PIXELS_PER_COL = 12'h008;
   localparam logic [11:0] NTSC_EXTRA     = 12'h006;
   localparam logic [11:0] PAL_EXTRA      = 12'h007;
   localparam logic [10:0] ONE_LINE       = 11'h001;

endpackage : dft_pkg

//--- testbench/dft_frame_timing_properties.sv
`timescale 1ns/100ps
module dft_frame_timing_properties
   import dft_pkg::*;
(
   // Clock, reset and bus.
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [11:0] adr_i,
   input wire logic [3:0]  sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   // Timing outputs.
   input wire logic        panelPixelStrobe,
   input wire logic        panelDisplayEnable,
   input wire logic        panelLineStart,
   input wire logic        panelFrameStart,
   input wire logic        monitorDisplayEnable,
   input wire logic        monitorFrameStart
);
   logic [7:0] ctl;
   wire        ctlWr = cyc_i && stb_i && we_i && ack_o && sel_i[0]
                       && adr_i[11:2] == IDX_PATH_CONTROL;
   // Shadow of the control byte, taken at the same edge as the block.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) ctl <= REG_RESET;
      else if (ctlWr) ctl <= dat_i[7:0];
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   property p_ackPulse; ack_o |=> !ack_o; endproperty
   a_ackPulse: assert property (p_ackPulse) else $error("ack too long");
   property p_ackReq; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
   a_ackReq: assert property (p_ackReq) else $error("ack missing");
   property p_ackCause; ack_o |-> $past(cyc_i && stb_i); endproperty
   a_ackCause: assert property (p_ackCause) else $error("ack unasked");
   property p_datIdle; !ack_o |-> dat_o == 32'h0000_0000; endproperty
   a_datIdle: assert property (p_datIdle) else $error("data outside ack");
   property p_panelAct; $rose(panelDisplayEnable) |-> panelDisplayEnable [*8]; endproperty
   a_panelAct: assert property (p_panelAct) else $error("short panel run");
   property p_panelEnd; panelLineStart |-> !$past(panelDisplayEnable); endproperty
   a_panelEnd: assert property (p_panelEnd) else $error("line ends active");
   property p_monBlank; $fell(monitorDisplayEnable) |-> !monitorDisplayEnable [*6]; endproperty
   a_monBlank: assert property (p_monBlank) else $error("short blank");
   property p_panelOff;
      !ctl[CTL_PANEL_ON] [*3] |-> !(panelPixelStrobe || panelDisplayEnable || panelLineStart);
   endproperty
   a_panelOff: assert property (p_panelOff) else $error("panel runs while off");
   c_panelFrame: cover property (panelFrameStart);
   c_monFrame: cover property (monitorFrameStart);
   c_write: cover property (ack_o && we_i);
endmodule : dft_frame_timing_properties
bind dft_frame_timing dft_frame_timing_properties i_props (.clk(clk), .reset(reset),
   .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
   .dat_o(dat_o), .ack_o(ack_o), .panelPixelStrobe(panelPixelStrobe),
   .panelDisplayEnable(panelDisplayEnable), .panelLineStart(panelLineStart),
   .panelFrameStart(panelFrameStart), .monitorDisplayEnable(monitorDisplayEnable),
   .monitorFrameStart(monitorFrameStart));

//--- testbench/dft_display_sink.sv
`timescale 1ns/100ps
module dft_display_sink (
   // Clock and reset.
   input wire logic    clk,
   input wire logic    reset,
   // Timing seen by the display.
   input wire logic    dispEn,
   input wire logic    lineStb,
   input wire logic    frameStb,
   input wire logic    pixStb,
   // Measured lengths in clock cycles, plus pixel strobe and frame counts.
   output logic [31:0] lineClk,
   output logic [31:0] lineAct,
   output logic [31:0] frameClk,
   output logic [31:0] frameAct,
   output logic [31:0] framePix,
   output logic [31:0] frames
);
   logic [31:0] lc, la, fc, fa, fp;
   wire  [31:0] en = {31'h0000_0000, dispEn};
   wire  [31:0] px = {31'h0000_0000, pixStb};
   wire         cut = lineStb || frameStb;
   // Only lines with pixels are latched, so a short last line is skipped.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         {lc, la, fc, fa, fp, lineClk, lineAct, frameClk, frameAct, framePix, frames} <= '0;
      end else begin
         lc <= cut ? 32'h0000_0001 : lc + 32'h0000_0001;
         la <= cut ? en : la + en;
         fc <= frameStb ? 32'h0000_0001 : fc + 32'h0000_0001;
         fa <= frameStb ? en : fa + en;
         fp <= frameStb ? px : fp + px;
         if (lineStb && la != 32'h0000_0000) begin
            lineClk <= lc;
            lineAct <= la;
         end
         if (frameStb) begin
            frameClk <= fc;
            frameAct <= fa;
            framePix <= fp;
            frames   <= frames + 32'h0000_0001;
         end
      end
   end
endmodule : dft_display_sink

//--- testbench/display_frame_timing_tb.sv
`timescale 1ns/100ps
module display_frame_timing_tb;
   import dft_pkg::*;
   logic        clk, reset, cyc_i, stb_i, we_i, ack_o, pEn, pLine, pFrame, mEn, mLine, mFrame;
   logic [11:0] adr_i;
   logic [3:0]  sel_i;
   logic        pStb, mStb;
   logic [31:0] dat_i, dat_o, rd;
   logic [31:0] pMeas [6];
   logic [31:0] mMeas [6];
   logic [7:0]  r [10];
   logic [9:0]  regIdx [10] = '{10'h032, 10'h034, 10'h038, 10'h039, 10'h03a,
                                10'h050, 10'h052, 10'h056, 10'h057, 10'h058};
   logic [7:0]  fieldMask [10] = '{8'h7f, 8'h1f, 8'hff, 8'h03, 8'h3f,
                                   8'h7f, 8'h3f, 8'hff, 8'h03, 8'h7f};
   int          fails, samplesChecked, pe [5], me [5];
   dft_frame_timing i_dut (.clk(clk), .reset(reset), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .panelPixelStrobe(pStb), .panelDisplayEnable(pEn), .panelLineStart(pLine),
      .panelFrameStart(pFrame), .monitorPixelStrobe(mStb), .monitorDisplayEnable(mEn),
      .monitorLineStart(mLine), .monitorFrameStart(mFrame));
   dft_display_sink i_panel (.clk(clk), .reset(reset), .dispEn(pEn), .lineStb(pLine),
      .frameStb(pFrame), .pixStb(pStb), .lineClk(pMeas[0]), .lineAct(pMeas[1]),
      .frameClk(pMeas[2]), .frameAct(pMeas[3]), .framePix(pMeas[5]), .frames(pMeas[4]));
   dft_display_sink i_monitor (.clk(clk), .reset(reset), .dispEn(mEn), .lineStb(mLine),
      .frameStb(mFrame), .pixStb(mStb), .lineClk(mMeas[0]), .lineAct(mMeas[1]),
      .frameClk(mMeas[2]), .frameAct(mMeas[3]), .framePix(mMeas[5]), .frames(mMeas[4]));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic complete_run;
      $display("fails %0d checked %0d", fails, samplesChecked);
      if (fails == 0 && samplesChecked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : complete_run
   task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
      samplesChecked++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t reg %h exp %h", $time, got, exp);
      end
   endtask : chkReg
   task automatic chkTime(input logic [31:0] got, input int exp);
      samplesChecked++;
      if (got !== 32'(exp)) begin
         fails++;
         $display("[ERR] %0t clocks %0d exp %0d", $time, got, exp);
      end
   endtask : chkTime
   task automatic hang;
      fails++;
      $display("[ERR] %0t wait ran out", $time);
      complete_run();
   endtask : hang
   task automatic wb(input logic w, input logic [9:0] idx, input logic [7:0] d);
      int n;
      @(posedge clk);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= {idx, 2'($urandom)};
      sel_i <= 4'($urandom) | 4'h1;
      dat_i <= {24'($urandom), d};
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      if (ack_o !== 1'b1) hang();
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask : wb
   task automatic waitFrames;
      logic [31:0] p0, m0;
      int n;
      p0 = pMeas[4];
      m0 = mMeas[4];
      for (n = 0; n < 60000 && (pMeas[4] < p0 + 3 || mMeas[4] < m0 + 3); n++) @(posedge clk);
      if (n >= 60000) hang();
   endtask : waitFrames
   initial begin
      int m, v, vb, a, t, dp, dm;
      logic tv, pal, dual;
      {reset, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = '0;
      reset = 1'b1;
      fails = 0;
      samplesChecked = 0;
      void'($urandom(85877));
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      for (int k = 0; k < 10; k++) begin
         wb(1'b0, regIdx[k], 8'h00);
         chkReg(rd, {24'h00_0000, REG_RESET});
         r[k] = 8'($urandom);
         wb(1'b1, regIdx[k], r[k]);
         wb(1'b0, regIdx[k], 8'h00);
         chkReg(rd, {24'h00_0000, r[k]});
      end
      wb(1'b1, 10'h3ff, 8'h5a);
      wb(1'b0, 10'h3ff, 8'h00);
      chkReg(rd, 32'h0000_0000);
      for (int k = 0; k < 3; k++) begin
         wb(1'b1, IDX_PATH_STATUS + 10'(k), 8'($urandom));
         wb(1'b0, IDX_PATH_STATUS + 10'(k), 8'h00);
         chkReg(rd, 32'h0000_0000);
      end
      chkTime(pMeas[4], 0);
      chkTime(mMeas[4], 0);
      for (int i = 0; i < 6; i++) begin
         reset <= 1'b1;
         repeat (2) @(posedge clk);
         reset <= 1'b0;
         m = (i == 0) ? 0 : 3;
         dual = i[0];
         pal = i[0];
         tv = i > 1;
         dp = (i == 0) ? 0 : $urandom % 2;
         dm = (i == 0) ? 0 : $urandom % 2;
         for (int k = 0; k < 10; k++) begin
            r[k] = (8'($urandom) & ~fieldMask[k])
                   | ((k % 5 == 3) ? 8'(i == 0) : 8'($urandom % (m + 1)));
            wb(1'b1, regIdx[k], r[k]);
         end
         wb(1'b1, IDX_PIXEL_DIVIDER, {4'(dm), 4'(dp)});
         wb(1'b1, IDX_PATH_CONTROL, {3'b000, pal, tv, 1'b1, dual, 1'b1});
         waitFrames();
         a = ((r[0] & 8'h7f) + 1) * 8;
         t = a + ((r[1] & 8'h1f) + 1) * 8;
         v = {r[3][1:0], r[2]} + 1;
         if (dual) v = (v + 1) / 2;
         vb = (r[4] & 8'h3f) + 1;
         pe = '{t * (dp + 1), a * (dp + 1), (v + vb) * t * (dp + 1), v * a * (dp + 1),
                (v + vb) * t};
         a = ((r[5] & 8'h7f) + 1) * 8;
         t = a + (tv ? (r[6] & 8'h3f) * 8 + (pal ? 7 : 6) : ((r[6] & 8'h3f) + 1) * 8);
         v = {r[8][1:0], r[7]} + 1;
         vb = (r[9] & 8'h7f) + 1;
         me = '{t * (dm + 1), a * (dm + 1), ((v + vb) * t + (tv ? t / 2 : 0)) * (dm + 1),
                v * a * (dm + 1), (v + vb) * t + (tv ? t / 2 : 0)};
         for (int k = 0; k < 4; k++) begin
            chkTime(pMeas[k], pe[k]);
            chkTime(mMeas[k], me[k]);
         end
         chkTime(pMeas[5], pe[4]);
         chkTime(mMeas[5], me[4]);
      end
      complete_run();
   end
endmodule : display_frame_timing_tb
